// ---- include/ecc_ram_pkg.sv ----
// Constants, types and layouts for the error-corrected RAM controller.
// Assumes a single 50 MHz system clock and a synchronous active-high reset.
package ecc_ram_pkg;
  localparam int DATA_W = 32;
  localparam int CHK_W = 7;
  localparam int SYN_W = 6;
  localparam int CODE_LEN = 38;
  localparam int ADDR_W = 32;
  localparam int RAM_BYTES = 32768;
  localparam int RAM_WORDS = 8192;
  localparam int WORD_LSB = 2;
  localparam int REGION_LSB = 15;
  localparam logic [ADDR_W-1:0] RAM_BASE = 32'h00ff8000;
  localparam logic [ADDR_W-1:0] RAM_LAST = 32'h00ffffff;
  localparam int ACCESS_CYCLES = 2;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
  localparam logic [CHK_W-1:0] CHK_RST = 7'h00;

  // Bus request from a master
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic we;
    logic [DATA_W-1:0] wdata;
  } req_s;

  // Correction control set, written as one group
  typedef struct packed {
    logic ecc_on;
    logic upd_en;
    logic test_en;
    logic [CHK_W-1:0] test_flip;
  } cfg_s;

  localparam cfg_s CFG_RST = '{1'b1, 1'b1, 1'b0, CHK_RST};

  typedef enum logic {ST_IDLE, ST_ACCESS} acc_e;
endpackage

// ---- rtl/ecc_ram_ctrl.sv ----
// Error-corrected RAM region with status capture and interrupt requests.
// Assumes masters hold REQ until ACK and that config ports are synchronous.
`timescale 1ns/1ps
module ecc_ram_ctrl #(
  parameter int DEPTH = ecc_ram_pkg::RAM_WORDS
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Master access
  input wire logic REQ,
  input wire ecc_ram_pkg::req_s REQ_BUS,
  output logic ACK,
  output logic [ecc_ram_pkg::DATA_W-1:0] RDATA,
  // System control 1 and power state
  input wire logic CORRECTED_RAM_ENABLE,
  input wire logic STANDBY_RAM_ENABLE,
  input wire logic MODULE_STOP,
  input wire logic DEEP_STANDBY,
  output logic STANDBY_RAM_ON,
  // Correction controls and protection
  input wire logic CORRECTION_PROTECT_A,
  input wire logic CORRECTION_PROTECT_B,
  input wire logic CFG_WE,
  input wire ecc_ram_pkg::cfg_s CFG_IN,
  output ecc_ram_pkg::cfg_s CFG_OUT,
  // Error status, capture and clear
  input wire logic SINGLE_CLR,
  input wire logic DOUBLE_CLR,
  output logic SINGLE_ERROR_STATUS,
  output logic DOUBLE_ERROR_STATUS,
  output logic [ecc_ram_pkg::ADDR_W-1:0] SINGLE_ERROR_ADDRESS,
  output logic [ecc_ram_pkg::ADDR_W-1:0] DOUBLE_ERROR_ADDRESS,
  // Error interrupt, routed by NMI_SELECT
  input wire logic NMI_SELECT,
  output logic NMI_REQ,
  output logic IRQ_REQ
);
  import ecc_ram_pkg::*;

  localparam int IDX_W = $clog2(DEPTH);

  // Elaboration check: the word index must cover DEPTH exactly
  if (DEPTH < 2 || DEPTH > RAM_WORDS || (1 << IDX_W) != DEPTH) begin : g_depth
    $error("DEPTH must be a power of two up to the region size");
  end

  // Check bits of a word: Hamming over positions 1..38 plus overall parity
  function automatic logic [CHK_W-1:0] chk_gen(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    int k;
    c = CHK_RST;
    k = 0;
    for (int p = 1; p <= CODE_LEN; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int j = 0; j < SYN_W; j++) begin
          if (p[j]) c[j] = c[j] ^ d[k];
        end
        k++;
      end
    end
    c[CHK_W-1] = ^d ^ ^c[SYN_W-1:0];
    return c;
  endfunction

  // Flip the data bit sitting at Hamming position syn, if any
  function automatic logic [DATA_W-1:0] fix(input logic [DATA_W-1:0] d,
                                             input logic [SYN_W-1:0] syn);
    logic [DATA_W-1:0] r;
    int k;
    r = d;
    k = 0;
    for (int p = 1; p <= CODE_LEN; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (syn == SYN_W'(p)) r[k] = ~r[k];
        k++;
      end
    end
    return r;
  endfunction

  // Storage: data and check bits in flip-flops
  logic [DATA_W-1:0] data_mem [DEPTH];
  logic [CHK_W-1:0] chk_mem [DEPTH];

  acc_e state_r, state_nxt;
  req_s req_r, req_nxt;
  cfg_s cfg_r, cfg_nxt;
  logic ack_r, ack_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic sbe_r, sbe_nxt, dbe_r, dbe_nxt;
  logic [ADDR_W-1:0] sadr_r, sadr_nxt, dadr_r, dadr_nxt;
  logic nmi_r, nmi_nxt, irq_r, irq_nxt, sby_r, sby_nxt;

  logic hit, live, mem_we;
  logic [IDX_W-1:0] idx;
  logic [DATA_W-1:0] rd_d;
  logic [CHK_W-1:0] rd_c, calc_c, wr_c;
  logic [SYN_W-1:0] syn;
  logic par_err, single_ev, double_ev;

  // Region decode and word index
  assign hit = REQ_BUS.addr[ADDR_W-1:REGION_LSB]
               == RAM_BASE[ADDR_W-1:REGION_LSB];
  // Enabled, running and powered; otherwise requests are not taken
  assign live = CORRECTED_RAM_ENABLE && !MODULE_STOP && !DEEP_STANDBY;
  assign idx = req_r.addr[IDX_W+WORD_LSB-1:WORD_LSB];

  // Decode of the stored word during the second access cycle
  always_comb begin
    rd_d = data_mem[idx];
    rd_c = chk_mem[idx];
    calc_c = chk_gen(rd_d);
    syn = rd_c[SYN_W-1:0] ^ calc_c[SYN_W-1:0];
    par_err = ^rd_d ^ ^rd_c;
    single_ev = 1'b0;
    double_ev = 1'b0;
    if (state_r == ST_ACCESS && !req_r.we && cfg_r.ecc_on) begin
      single_ev = par_err;
      double_ev = !par_err && (syn != '0);
    end
  end

  // Write path: test mode disturbs chosen check bits
  assign wr_c = chk_gen(req_r.wdata)
                ^ (cfg_r.test_en ? cfg_r.test_flip : CHK_RST);
  assign mem_we = state_r == ST_ACCESS && req_r.we;

  // Access sequencer, config, status and interrupts
  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    cfg_nxt = cfg_r;
    ack_nxt = 1'b0;
    rdata_nxt = rdata_r;
    sbe_nxt = sbe_r && !SINGLE_CLR;
    dbe_nxt = dbe_r && !DOUBLE_CLR;
    sadr_nxt = sadr_r;
    dadr_nxt = dadr_r;
    nmi_nxt = 1'b0;
    irq_nxt = 1'b0;
    sby_nxt = STANDBY_RAM_ENABLE;
    unique case (state_r)
      ST_IDLE: begin
        if (REQ && hit && live && !ack_r) begin
          req_nxt = REQ_BUS;
          state_nxt = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        ack_nxt = 1'b1;
        state_nxt = ST_IDLE;
        rdata_nxt = cfg_r.ecc_on ? fix(rd_d, syn) : rd_d;
      end
    endcase
    // Set beats clear; first error kept until cleared
    if (single_ev && cfg_r.upd_en) begin
      if (!sbe_r || SINGLE_CLR) sadr_nxt = req_r.addr;
      sbe_nxt = 1'b1;
    end
    if (double_ev) begin
      if (!dbe_r || DOUBLE_CLR) dadr_nxt = req_r.addr;
      dbe_nxt = 1'b1;
    end
    if (single_ev || double_ev) begin
      nmi_nxt = NMI_SELECT;
      irq_nxt = !NMI_SELECT;
    end
    // Both protect keys must be open for any config write
    if (CFG_WE && CORRECTION_PROTECT_A && CORRECTION_PROTECT_B)
      cfg_nxt = CFG_IN;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_r <= ST_IDLE;
      req_r <= '0;
      cfg_r <= CFG_RST;
      ack_r <= 1'b0;
      rdata_r <= DATA_RST;
      sbe_r <= 1'b0;
      dbe_r <= 1'b0;
      sadr_r <= ADDR_RST;
      dadr_r <= ADDR_RST;
      nmi_r <= 1'b0;
      irq_r <= 1'b0;
      sby_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      cfg_r <= cfg_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      sbe_r <= sbe_nxt;
      dbe_r <= dbe_nxt;
      sadr_r <= sadr_nxt;
      dadr_r <= dadr_nxt;
      nmi_r <= nmi_nxt;
      irq_r <= irq_nxt;
      sby_r <= sby_nxt;
    end
  end

  // Memory array; deep standby wipes it since it has no retention
  always_ff @(posedge CLK) begin
    if (DEEP_STANDBY) begin
      for (int i = 0; i < DEPTH; i++) begin
        data_mem[i] <= DATA_RST;
        chk_mem[i] <= ~CHK_RST;
      end
    end else if (mem_we) begin
      data_mem[idx] <= req_r.wdata;
      chk_mem[idx] <= wr_c;
    end
  end

  assign ACK = ack_r;
  assign RDATA = rdata_r;
  assign STANDBY_RAM_ON = sby_r;
  assign CFG_OUT = cfg_r;
  assign SINGLE_ERROR_STATUS = sbe_r;
  assign DOUBLE_ERROR_STATUS = dbe_r;
  assign SINGLE_ERROR_ADDRESS = sadr_r;
  assign DOUBLE_ERROR_ADDRESS = dadr_r;
  assign NMI_REQ = nmi_r;
  assign IRQ_REQ = irq_r;

  // Checks on timing, capture and routing
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_two_cycle_ack: assert property (
    (state_r == ST_IDLE && REQ && hit && live && !ack_r) |-> ##2 ack_r)
    else $error("access not answered in two cycles");
  a_ignored_off: assert property (
    (state_r == ST_IDLE && !CORRECTED_RAM_ENABLE) |=> state_r == ST_IDLE)
    else $error("access taken while RAM disabled");
  a_stop_halts: assert property (
    (state_r == ST_IDLE && MODULE_STOP) |=> !ack_r ##1 !ack_r)
    else $error("access answered in module stop");
  a_single_sets: assert property (
    (single_ev && cfg_r.upd_en) |=> sbe_r)
    else $error("single error not recorded");
  a_double_sets: assert property (
    (double_ev && !dbe_r) |=> dbe_r && dadr_r == $past(req_r.addr))
    else $error("double error or address not captured");
  a_single_addr: assert property (
    (single_ev && cfg_r.upd_en && !sbe_r) |=> sadr_r == $past(req_r.addr))
    else $error("single error address not captured");
  a_update_gate: assert property (
    (single_ev && !cfg_r.upd_en && !sbe_r) |=> !sbe_r && $stable(sadr_r))
    else $error("single status set while updates disabled");
  a_hold_first: assert property (
    (dbe_r && !DOUBLE_CLR) |=> $stable(dadr_r) && dbe_r)
    else $error("double error capture overwritten");
  a_irq_route: assert property (
    (single_ev || double_ev) |=>
      (nmi_r == $past(NMI_SELECT)) && (irq_r != nmi_r))
    else $error("error interrupt misrouted");
  a_protect_cfg: assert property (
    (!(CORRECTION_PROTECT_A && CORRECTION_PROTECT_B)) |=> $stable(cfg_r))
    else $error("config changed while protected");
  a_standby_bit: assert property (
    (STANDBY_RAM_ENABLE && !SYS_RST) |=> STANDBY_RAM_ON)
    else $error("standby RAM enable not followed");

  c_read_fixed: cover property (single_ev ##1 ack_r);
  c_double_hit: cover property (double_ev ##1 nmi_r);
  c_write_read: cover property (mem_we ##[1:8] (state_r == ST_ACCESS));
  c_set_and_clear: cover property (single_ev && SINGLE_CLR && sbe_r);
endmodule

// ---- tb/ecc_master_model.sv ----
// Bus master standing in for the processor side of the RAM port.
// Assumes the bench pulses START for one cycle while BUSY is low.
`timescale 1ns/1ps
module ecc_master_model (
  // Clock
  input wire logic CLK,
  // Bench command
  input wire logic START,
  input wire ecc_ram_pkg::req_s CMD,
  output logic BUSY = 1'b0,
  output logic [3:0] WAITS = 4'h0,
  // Port toward the controller
  input wire logic ACK,
  output logic REQ = 1'b0,
  output ecc_ram_pkg::req_s REQ_BUS = '0
);
  import ecc_ram_pkg::*;
  // Hold the request until ACK is sampled; withdraw after 8 silent edges
  always @(posedge CLK) begin
    if (START && !BUSY) begin
      REQ <= 1'b1;
      REQ_BUS <= CMD;
      BUSY <= 1'b1;
      WAITS <= 4'h0;
    end else if (BUSY) begin
      if (ACK || WAITS == 4'h8) begin
        REQ <= 1'b0;
        BUSY <= 1'b0;
        REQ_BUS <= ~REQ_BUS; // Released bus must not keep old value
      end else begin
        WAITS <= WAITS + 4'h1;
      end
    end
  end
endmodule

// ---- tb/ecc_ram_ctrl_bench.sv ----
// Self-checking bench for the corrected RAM controller.
// Assumes a 16-word array, so addresses alias inside the region.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module ecc_protected_ram_control_bench;
  import ecc_ram_pkg::*;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, busy, req, ack, sby_on;
  logic ram_en = 1'b1, sby_en = 1'b0, mstop = 1'b0, dstby = 1'b0;
  logic cfg_we = 1'b0, pa = 1'b0, pb = 1'b0, sclr = 1'b0, dclr = 1'b0;
  logic nmi_sel = 1'b0, sstat, dstat, nmi, irq;
  logic [3:0] waits;
  logic [31:0] rdata, saddr, daddr, a;
  logic [15:0] seed = 16'h002d;
  req_s cmd = '0, req_bus;
  cfg_s cfg_in = '0, cfg_out;
  int mismatches = 0, cmp_count = 0;
  logic [7:0] irq_n = 8'h00, nmi_n = 8'h00;
  localparam logic [31:0] B = RAM_BASE;

  always #10 clk = ~clk;
  // Count interrupt pulses per route; 4-state so an unknown pulse shows
  always @(posedge clk) begin
    if (!rst) begin
      irq_n <= irq_n + {7'h00, irq};
      nmi_n <= nmi_n + {7'h00, nmi};
    end
  end

  ecc_master_model u_master (.CLK(clk), .START(start), .CMD(cmd),
    .BUSY(busy), .WAITS(waits), .ACK(ack), .REQ(req), .REQ_BUS(req_bus));
  ecc_ram_ctrl #(.DEPTH(16)) u_dut (.CLK(clk), .SYS_RST(rst), .REQ(req),
    .REQ_BUS(req_bus), .ACK(ack), .RDATA(rdata),
    .CORRECTED_RAM_ENABLE(ram_en), .STANDBY_RAM_ENABLE(sby_en),
    .MODULE_STOP(mstop), .DEEP_STANDBY(dstby), .STANDBY_RAM_ON(sby_on),
    .CORRECTION_PROTECT_A(pa), .CORRECTION_PROTECT_B(pb), .CFG_WE(cfg_we),
    .CFG_IN(cfg_in), .CFG_OUT(cfg_out), .SINGLE_CLR(sclr),
    .DOUBLE_CLR(dclr), .SINGLE_ERROR_STATUS(sstat),
    .DOUBLE_ERROR_STATUS(dstat), .SINGLE_ERROR_ADDRESS(saddr),
    .DOUBLE_ERROR_ADDRESS(daddr), .NMI_SELECT(nmi_sel), .NMI_REQ(nmi),
    .IRQ_REQ(irq));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // One access through the master; WAITS tells accepted from refused
  task automatic access(input logic we, input logic [31:0] ad,
                        input logic [31:0] d);
    @(posedge clk);
    cmd <= '{ad, we, d};
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (14) begin
      @(posedge clk);
      #1;
      if (!busy) break;
    end
  endtask

  // Config write, with protect A as given and protect B high
  task automatic set_cfg(input cfg_s c, input logic lock_a);
    @(posedge clk);
    cfg_in <= c;
    pa <= lock_a;
    pb <= 1'b1;
    cfg_we <= 1'b1;
    @(posedge clk);
    cfg_we <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic final_report;
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run of about three hundred cycles
  initial begin
    #200000;
    mismatches++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(cfg_out, CFG_RST)
    `CHK(sstat, 1'b0)
    // Random words, plus the last word of the region
    for (int i = 0; i < 13; i++) begin
      seed = lfsr(seed);
      a = (i == 12) ? 32'h00fffffc : (B | {26'h0, seed[3:0], 2'b00});
      access(1'b1, a, {seed, ~seed});
      `CHK(waits, 4'h2)
      access(1'b0, a, 32'h0);
      `CHK(waits, 4'h2)
      `CHK(rdata, {seed, ~seed})
    end
    // Out of region, disabled, stopped: never answered
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      ram_en <= (k != 1);
      mstop <= (k == 2);
      access(1'b0, (k == 0) ? 32'h00ff7ffc : B, 32'h0);
      `CHK(waits, 4'h8)
    end
    @(posedge clk);
    ram_en <= 1'b1;
    mstop <= 1'b0;
    set_cfg('{1'b0, 1'b0, 1'b1, 7'h01}, 1'b0);
    `CHK(cfg_out, CFG_RST)
    // Single errors planted in two words
    set_cfg('{1'b1, 1'b1, 1'b1, 7'h01}, 1'b1);
    `CHK(cfg_out.test_en, 1'b1)
    access(1'b1, B + 32'h8, 32'h5a5a0f0f);
    access(1'b1, B + 32'hc, 32'h12345678);
    // Data bit 0 stored wrong against the check bits of the right word
    set_cfg('{1'b1, 1'b1, 1'b1, 7'h43}, 1'b1);
    access(1'b1, B + 32'h14, 32'h5a5a0f0e);
    set_cfg(CFG_RST, 1'b1);
    access(1'b0, B + 32'h8, 32'h0);
    `CHK(waits, 4'h2)
    `CHK(rdata, 32'h5a5a0f0f)
    `CHK(sstat, 1'b1)
    `CHK(saddr, B + 32'h8)
    `CHK(irq_n, 8'h01)
    access(1'b0, B + 32'hc, 32'h0);
    `CHK(saddr, B + 32'h8)
    // Double error routed to the non-maskable request
    @(posedge clk);
    nmi_sel <= 1'b1;
    set_cfg('{1'b1, 1'b1, 1'b1, 7'h03}, 1'b1);
    access(1'b1, B + 32'h4, 32'hcafef00d);
    set_cfg(CFG_RST, 1'b1);
    access(1'b0, B + 32'h4, 32'h0);
    `CHK(dstat, 1'b1)
    `CHK(daddr, B + 32'h4)
    `CHK(nmi_n, 8'h01)
    `CHK(irq_n, 8'h02)
    @(posedge clk);
    sclr <= 1'b1;
    dclr <= 1'b1;
    @(posedge clk);
    sclr <= 1'b0;
    dclr <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({sstat, dstat}, 2'b00)
    // Updates disabled, then correction off
    set_cfg('{1'b1, 1'b0, 1'b0, 7'h00}, 1'b1);
    access(1'b0, B + 32'h8, 32'h0);
    `CHK(sstat, 1'b0)
    `CHK(rdata, 32'h5a5a0f0f)
    access(1'b0, B + 32'h14, 32'h0);
    `CHK(rdata, 32'h5a5a0f0f)
    `CHK(sstat, 1'b0)
    set_cfg('{1'b0, 1'b1, 1'b0, 7'h00}, 1'b1);
    access(1'b0, B + 32'hc, 32'h0);
    `CHK(sstat, 1'b0)
    access(1'b0, B + 32'h14, 32'h0);
    `CHK(rdata, 32'h5a5a0f0e)
    `CHK(sstat, 1'b0)
    set_cfg(CFG_RST, 1'b1);
    // Standby RAM enable and deep standby wipe
    @(posedge clk);
    sby_en <= 1'b1;
    dstby <= 1'b1;
    repeat (2) @(posedge clk);
    dstby <= 1'b0;
    #1;
    `CHK(sby_on, 1'b1)
    access(1'b0, B, 32'h0);
    `CHK(sstat | dstat, 1'b1)
    `CHK(rdata, 32'h0)
    // Clear pulse lands in the decode cycle of a new single error
    fork
      access(1'b0, B + 32'h10, 32'h0);
      begin
        repeat (3) @(posedge clk);
        sclr <= 1'b1;
        @(posedge clk);
        sclr <= 1'b0;
      end
    join
    `CHK(sstat, 1'b1)
    `CHK(saddr, B + 32'h10)
    // Reset in mid-run clears the sticky capture but not the array
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({sstat, dstat}, 2'b00)
    `CHK(saddr, ADDR_RST)
    access(1'b1, B, 32'h0f0f5a5a);
    `CHK(waits, 4'h2)
    final_report();
  end
endmodule
